/* rtl/tws_pkg.sv */
// constants, register map and state codes of the two-wire status unit
package tws_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned BIT_NS = 10000;
  // quarter of a bit period in clock cycles, rounded down
  localparam int unsigned QTR_CYC = BIT_NS / (4 * CLK_NS);
  localparam logic [7:0] QTR_LOAD = 8'(QTR_CYC - 1);

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_OWN = 8'h0c;
  localparam logic [7:0] OFF_IST = 8'h10;
  localparam logic [7:0] OFF_ICLR = 8'h14;
  localparam logic [7:0] OFF_IEN = 8'h18;

  // ------------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------------
  localparam int unsigned CB_FLAG = 7;
  localparam int unsigned CB_ACK = 6;
  localparam int unsigned CB_STA = 5;
  localparam int unsigned CB_STO = 4;
  localparam int unsigned CB_WCOL = 3;
  localparam int unsigned CB_EN = 2;

  // interrupt status, clear and enable share this layout
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IB_FLAG = 0;
  localparam int unsigned IB_WCOL = 1;
  localparam int unsigned IB_STOP = 2;

  // ------------------------------------------------------------------
  // status codes, low three bits always zero
  // ------------------------------------------------------------------
  localparam logic [7:0] SC_START = 8'h08;
  localparam logic [7:0] SC_RSTART = 8'h10;
  localparam logic [7:0] SC_WADR_ACK = 8'h18;
  localparam logic [7:0] SC_WADR_NACK = 8'h20;
  localparam logic [7:0] SC_DATA_SENT_ACKED = 8'h28;
  localparam logic [7:0] SC_DATA_SENT_NACKED = 8'h30;
  localparam logic [7:0] SC_RADR_ACK = 8'h40;
  localparam logic [7:0] SC_RADR_NACK = 8'h48;
  localparam logic [7:0] SC_DATA_RCVD_ACKED = 8'h50;
  localparam logic [7:0] SC_DATA_RCVD_NACKED = 8'h58;
  localparam logic [7:0] SC_SLV_WADR = 8'h60;
  localparam logic [7:0] SC_SLV_RX_ACK = 8'h80;
  localparam logic [7:0] SC_SLV_RX_NACK = 8'h88;
  localparam logic [7:0] SC_SLV_STOP = 8'ha0;
  localparam logic [7:0] SC_SLV_RADR = 8'ha8;
  localparam logic [7:0] SC_SLV_TX_ACK = 8'hb8;
  localparam logic [7:0] SC_SLV_TX_NACK = 8'hc0;
  localparam logic [7:0] SC_IDLE = 8'hf8;

  // ------------------------------------------------------------------
  // reset values and counters
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [6:0] OWN_RST = 7'h00;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [1:0] PH_DRV = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_SAMP = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_START = 5'b00010,
    S_XFER = 5'b00100,
    S_HOLD = 5'b01000,
    S_STOP = 5'b10000
  } tws_state_type;

endpackage : tws_pkg

/* rtl/tws_sync.sv */
// two-flop synchronisers with edge detection for the bus pins
`timescale 1ns/1ps
module tws_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // raw pins and synchronised results
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);

  // ------------------------------------------------------------------
  // one chain per pin
  // ------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      logic meta_q;
      logic sync_q;
      logic prev_q;
      // idle bus is high, so reset to one to avoid false edges
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
          prev_q <= 1'b1;
        end else begin
          meta_q <= pin_i[i];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      assign sync_o[i] = sync_q;
      assign rise_o[i] = sync_q & ~prev_q;
      assign fall_o[i] = ~sync_q & prev_q;
    end
  endgenerate

endmodule : tws_sync

/* rtl/tws_ahb.sv */
// ahb-lite slave front end: address capture, write strobe, read wait
`timescale 1ns/1ps
module tws_ahb (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // register side
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);

  // ------------------------------------------------------------------
  // address phase accept
  // ------------------------------------------------------------------
  logic acc;
  logic [7:0] addr_q;
  logic wr_q;
  logic rd_q;
  logic rdy_q;
  logic [31:0] rdata_q;

  assign acc = hsel & htrans[1] & hready;

  // reads get one wait state so a write just before is already visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rdy_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (acc) begin
        addr_q <= haddr[7:0];
      end
      wr_q <= acc & hwrite;
      rd_q <= acc & ~hwrite;
      rdy_q <= ~(acc & ~hwrite);
      if (rd_q) begin
        rdata_q <= reg_rdata;
      end
    end
  end

  assign reg_addr = addr_q;
  assign reg_wr = wr_q;
  assign reg_rd = rd_q;
  assign hrdata = rdata_q;
  assign hreadyout = rdy_q;
  assign hresp = 1'b0; // always okay

endmodule : tws_ahb

/* rtl/tws_top.sv */
// two-wire unit: status-driven byte engine with ahb-lite registers
`timescale 1ns/1ps
module tws_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // two-wire bus pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // interrupt
  output logic irq
);

  // ------------------------------------------------------------------
  // bus front end and pin synchronisers
  // ------------------------------------------------------------------
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [1:0] pin_s;
  logic [1:0] pin_r;
  logic [1:0] pin_f;

  tws_ahb u_ahb (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  // bit 1 is the clock line, bit 0 the data line
  tws_sync #(.W(2)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_i({scl_i, sda_i}),
    .sync_o(pin_s),
    .rise_o(pin_r),
    .fall_o(pin_f)
  );

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  tws_pkg::tws_state_type state_q;
  logic flag_q, ack_en_q, sta_q, sto_q, wcol_q, en_q;
  logic [7:0] status_q;
  logic [7:0] data_q;
  logic [6:0] own_q;
  logic [tws_pkg::IRQ_W-1:0] ist_q;
  logic [tws_pkg::IRQ_W-1:0] ien_q;
  logic irq_q;
  logic [7:0] shreg_q;
  logic [3:0] bitcnt_q;
  logic [1:0] phase_q;
  logic [7:0] qcnt_q;
  logic master_q, first_q, tx_q, rw_q, nack_q, rep_q, sampled_q;
  logic busy_q;
  logic scl_oe_q, sda_oe_q;

  // ------------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------------
  wire sel_ctrl = reg_addr == tws_pkg::OFF_CTRL;
  wire sel_stat = reg_addr == tws_pkg::OFF_STAT;
  wire sel_data = reg_addr == tws_pkg::OFF_DATA;
  wire sel_own = reg_addr == tws_pkg::OFF_OWN;
  wire sel_ist = reg_addr == tws_pkg::OFF_IST;
  wire sel_iclr = reg_addr == tws_pkg::OFF_ICLR;
  wire sel_ien = reg_addr == tws_pkg::OFF_IEN;
  wire wr_ctrl = reg_wr & sel_ctrl;
  wire wr_data = reg_wr & sel_data;
  // writing one to the flag bit clears it
  wire flag_clr = wr_ctrl & hwdata[tws_pkg::CB_FLAG];
  // out of the hold state, a byte only moves when enable is written together with the clear
  wire go = flag_clr & hwdata[tws_pkg::CB_EN];
  wire data_ok = wr_data & flag_q;
  wire data_col = wr_data & ~flag_q;
  wire [7:0] ctrl_rd = {flag_q, ack_en_q, sta_q, sto_q, wcol_q, en_q, 2'h0};
  // prescaler bits read as zero, software masks them anyway
  wire [7:0] stat_rd = {status_q[7:3], 3'h0};

  assign reg_rdata = sel_ctrl ? {24'h00_0000, ctrl_rd} :
                     sel_stat ? {24'h00_0000, stat_rd} :
                     sel_data ? {24'h00_0000, data_q} :
                     sel_own ? {24'h00_0000, own_q, 1'b0} :
                     sel_ist ? {29'h0000_0000, ist_q} :
                     sel_ien ? {29'h0000_0000, ien_q} : 32'h0000_0000;

  // ------------------------------------------------------------------
  // bus conditions and bit timing
  // ------------------------------------------------------------------
  wire scl_s = pin_s[1];
  wire sda_s = pin_s[0];
  wire bus_start = pin_f[0] & scl_s;
  wire bus_stop = pin_r[0] & scl_s;
  wire tick = qcnt_q == 8'h00;
  // the master waits in the sample phase while a slave stretches the clock
  wire ph_adv = tick & ~((phase_q == tws_pkg::PH_SAMP) & ~scl_s);
  wire m_samp = ph_adv & (phase_q == tws_pkg::PH_SAMP);
  wire m_fall = ph_adv & (phase_q == tws_pkg::PH_FALL);
  wire samp = master_q ? m_samp : pin_r[1];
  wire done = sampled_q & (master_q ? m_fall : pin_f[1]);
  wire ack_bit = bitcnt_q == tws_pkg::BIT_ACK;
  wire match = shreg_q[7:1] == own_q;
  // slaves acknowledge their address only when acking is enabled
  wire ack_out = (~master_q & first_q) ? (match & ack_en_q) : ack_en_q;
  // pulling low sends zero or an acknowledge, release sends one
  wire drv_oe = ack_bit ? (~tx_q & ack_out) : (tx_q & ~shreg_q[7]);
  wire byte_end = (state_q == tws_pkg::S_XFER) & done & ack_bit;
  wire slv_drop = ~master_q & first_q & ~(match & ack_en_q);
  wire slv_stop = ~master_q & bus_stop &
                  ((state_q == tws_pkg::S_XFER) |
                   (state_q == tws_pkg::S_HOLD));

  // status code posted at the end of a byte, per role
  logic [7:0] end_code;
  assign end_code = master_q ?
    (first_q ? (shreg_q[0] ? (nack_q ? tws_pkg::SC_RADR_NACK :
                                       tws_pkg::SC_RADR_ACK) :
                             (nack_q ? tws_pkg::SC_WADR_NACK :
                                       tws_pkg::SC_WADR_ACK)) :
     tx_q ? (nack_q ? tws_pkg::SC_DATA_SENT_NACKED :
                      tws_pkg::SC_DATA_SENT_ACKED) :
            (nack_q ? tws_pkg::SC_DATA_RCVD_NACKED :
                      tws_pkg::SC_DATA_RCVD_ACKED)) :
    (first_q ? (shreg_q[0] ? tws_pkg::SC_SLV_RADR :
                             tws_pkg::SC_SLV_WADR) :
     tx_q ? (nack_q ? tws_pkg::SC_SLV_TX_NACK :
                      tws_pkg::SC_SLV_TX_ACK) :
            (nack_q ? tws_pkg::SC_SLV_RX_NACK :
                      tws_pkg::SC_SLV_RX_ACK));

  wire start_end = (state_q == tws_pkg::S_START) & m_fall;
  wire flag_set = start_end | (byte_end & ~slv_drop) | (slv_stop & ~first_q);
  wire [tws_pkg::IRQ_W-1:0] ev;
  assign ev = {slv_stop | ((state_q == tws_pkg::S_STOP) & m_fall),
               data_col, flag_set};

  // ------------------------------------------------------------------
  // software-visible registers
  // ------------------------------------------------------------------
  // set wins over clear on every hardware flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {flag_q, ack_en_q, sta_q, sto_q, wcol_q, en_q} <= tws_pkg::CTRL_RST[7:2];
      own_q <= tws_pkg::OWN_RST;
      ien_q <= '0;
      ist_q <= '0;
      irq_q <= 1'b0;
    end else begin
      flag_q <= flag_set | (flag_q & ~flag_clr);
      wcol_q <= data_col | (wcol_q & ~data_ok);
      if (wr_ctrl) begin
        ack_en_q <= hwdata[tws_pkg::CB_ACK];
        sta_q <= hwdata[tws_pkg::CB_STA];
        en_q <= hwdata[tws_pkg::CB_EN];
      end
      // stop bit self-clears once the stop has gone out
      if (wr_ctrl) begin
        sto_q <= hwdata[tws_pkg::CB_STO];
      end else if (ev[tws_pkg::IB_STOP] & master_q) begin
        sto_q <= 1'b0;
      end
      if (reg_wr & sel_own) begin
        own_q <= hwdata[7:1];
      end
      if (reg_wr & sel_ien) begin
        ien_q <= hwdata[tws_pkg::IRQ_W-1:0];
      end
      ist_q <= ev | (ist_q & ~({tws_pkg::IRQ_W{reg_wr & sel_iclr}} &
                               hwdata[tws_pkg::IRQ_W-1:0]));
      irq_q <= |(ist_q & ien_q);
    end
  end

  // quarter-bit divider, free running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qcnt_q <= tws_pkg::QTR_LOAD;
    end else begin
      qcnt_q <= tick ? tws_pkg::QTR_LOAD : qcnt_q - 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // byte engine
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= tws_pkg::S_IDLE;
      status_q <= tws_pkg::SC_IDLE;
      data_q <= 8'h00;
      shreg_q <= 8'h00;
      bitcnt_q <= 4'h0;
      phase_q <= tws_pkg::PH_DRV;
      {master_q, first_q, tx_q, rw_q, nack_q, rep_q, sampled_q} <= 7'h00;
      busy_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      busy_q <= bus_start | (busy_q & ~bus_stop);
      if (data_ok) begin
        data_q <= hwdata[7:0];
      end
      if (ph_adv) begin
        phase_q <= phase_q + 2'h1;
      end
      if (samp & (state_q == tws_pkg::S_XFER)) begin
        sampled_q <= 1'b1;
        if (ack_bit) begin
          nack_q <= sda_s;
        end else begin
          shreg_q <= {shreg_q[6:0], sda_s};
        end
      end
      if (!en_q) begin
        // disabling drops the bus at once
        state_q <= tws_pkg::S_IDLE;
        master_q <= 1'b0;
        scl_oe_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else begin
        case (state_q)
          tws_pkg::S_IDLE: begin
            if (sta_q & ~flag_q & ~busy_q) begin
              state_q <= tws_pkg::S_START;
              rep_q <= 1'b0;
              phase_q <= tws_pkg::PH_DRV;
            end else if (bus_start) begin
              state_q <= tws_pkg::S_XFER;
              {master_q, first_q, tx_q, sampled_q} <= 4'h4;
              bitcnt_q <= 4'h0;
            end
          end
          tws_pkg::S_START: begin
            if (ph_adv) begin
              case (phase_q)
                tws_pkg::PH_DRV: sda_oe_q <= 1'b0;
                tws_pkg::PH_RISE: scl_oe_q <= 1'b0;
                tws_pkg::PH_SAMP: sda_oe_q <= 1'b1;
                default: begin
                  // start is out: report it and park the clock low
                  scl_oe_q <= 1'b1;
                  status_q <= rep_q ? tws_pkg::SC_RSTART :
                                      tws_pkg::SC_START;
                  {master_q, first_q} <= 2'h3;
                  state_q <= tws_pkg::S_HOLD;
                end
              endcase
            end
          end
          tws_pkg::S_XFER: begin
            if (master_q & ph_adv) begin
              case (phase_q)
                tws_pkg::PH_DRV: sda_oe_q <= drv_oe;
                tws_pkg::PH_RISE: scl_oe_q <= 1'b0;
                tws_pkg::PH_SAMP: sda_oe_q <= sda_oe_q;
                default: scl_oe_q <= 1'b1;
              endcase
            end else if (~master_q & ~scl_s) begin
              sda_oe_q <= drv_oe; // data changes only while clock is low
            end
            if (done) begin
              sampled_q <= 1'b0;
              if (ack_bit) begin
                sda_oe_q <= 1'b0;
                first_q <= 1'b0;
                if (first_q) begin
                  rw_q <= shreg_q[0];
                end
                if (~tx_q) begin
                  data_q <= shreg_q;
                end
                if (slv_drop) begin
                  state_q <= tws_pkg::S_IDLE;
                end else begin
                  status_q <= end_code;
                  state_q <= tws_pkg::S_HOLD;
                  scl_oe_q <= 1'b1;
                end
              end else begin
                bitcnt_q <= bitcnt_q + 4'h1;
              end
            end
            if (slv_stop) begin
              state_q <= tws_pkg::S_IDLE;
              sda_oe_q <= 1'b0;
              if (~first_q) begin
                status_q <= tws_pkg::SC_SLV_STOP;
              end
            end
          end
          tws_pkg::S_HOLD: begin
            // nothing moves on the bus until software clears the flag
            if (slv_stop) begin
              state_q <= tws_pkg::S_IDLE;
              scl_oe_q <= 1'b0;
              status_q <= tws_pkg::SC_SLV_STOP;
            end else if (go) begin
              phase_q <= tws_pkg::PH_DRV;
              if (master_q & hwdata[tws_pkg::CB_STO]) begin
                state_q <= tws_pkg::S_STOP;
              end else if (master_q & hwdata[tws_pkg::CB_STA]) begin
                state_q <= tws_pkg::S_START;
                rep_q <= 1'b1;
              end else if (~master_q & nack_q) begin
                state_q <= tws_pkg::S_IDLE;
                scl_oe_q <= 1'b0;
              end else begin
                state_q <= tws_pkg::S_XFER;
                shreg_q <= data_q;
                bitcnt_q <= 4'h0;
                sampled_q <= 1'b0;
                tx_q <= master_q ? (first_q | ~rw_q) : rw_q;
                if (~master_q) begin
                  scl_oe_q <= 1'b0;
                end
              end
            end
          end
          tws_pkg::S_STOP: begin
            if (ph_adv) begin
              case (phase_q)
                tws_pkg::PH_DRV: sda_oe_q <= 1'b1;
                tws_pkg::PH_RISE: scl_oe_q <= 1'b0;
                tws_pkg::PH_SAMP: sda_oe_q <= 1'b0;
                default: begin
                  state_q <= tws_pkg::S_IDLE;
                  master_q <= 1'b0;
                  status_q <= tws_pkg::SC_IDLE;
                end
              endcase
            end
          end
          default: state_q <= tws_pkg::S_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // open drain: the pin level is always low when driven
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign irq = irq_q;

endmodule : tws_top

/* sim/tws_top_assertions.sv */
// bus and line checker bound to the two-wire unit
`timescale 1ns/1ps
module tws_top_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // bus lines
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // request taken only on a ready bus
  wire take = hsel & htrans[1] & hready;
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  read_wait_a: assert property (take && !hwrite
    |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  rdata_hold_a: assert property (hreadyout && $past(hreadyout)
    |-> $stable(hrdata))
    else $error("read data moved");
  open_drain_a: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  clk_high_a: assert property ($fell(scl_oe) |-> !scl_oe [*8])
    else $error("clock high too short");
  clk_low_a: assert property ($rose(scl_oe) |-> scl_oe [*8])
    else $error("clock low too short");
  // data moving under a high clock is only start or stop
  start_hold_a: assert property ($rose(sda_oe) && !scl_oe && scl_i
    |=> !scl_oe [*4])
    else $error("start not held");
  stop_idle_a: assert property ($fell(sda_oe) && !scl_oe && scl_i
    |=> !sda_oe [*8])
    else $error("stop not idle");
  cov_read: cover property (take && !hwrite);
  cov_start: cover property ($rose(sda_oe) && scl_i && !scl_oe);
  cov_clock: cover property ($fell(scl_oe));
endmodule : tws_top_chk

bind tws_top tws_top_chk i_tws_top_chk (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hrdata, .hresp, .scl_i, .scl_o, .scl_oe,
  .sda_o, .sda_oe);

/* sim/tws_target_model.sv */
// behavioural target device on the two-wire bus
`timescale 1ns/1ps
module tws_target_model (
  // lines as seen on the wire
  input wire logic scl,
  input wire logic sda,
  // behaviour chosen by the bench
  input wire logic nack,
  input wire logic slow,
  // pulls, high drives the line low
  output logic scl_pull,
  output logic sda_pull,
  output logic [7:0] last_byte
);
  int cnt = 0;
  logic [7:0] sh = 8'h00;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    last_byte = 8'h00;
  end
  // start or stop restarts the bit count
  always @(sda) if (scl) cnt = 0;
  // sample on the rising clock, msb first
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    cnt = cnt + 1;
  end
  // ack slot; a stretch keeps the clock low, nothing else moves then
  always @(negedge scl) begin
    if (cnt == 8) sda_pull = !nack;
    if (cnt == 9) begin
      sda_pull = 1'b0;
      cnt = 0;
      last_byte = sh;
      if (slow) begin
        scl_pull = 1'b1;
        #3000 scl_pull = 1'b0;
      end
    end
  end
endmodule : tws_target_model

/* sim/tws_top_tb.sv */
// self-checking bench for the two-wire unit as bus master
`timescale 1ns/1ps
module tws_top_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic nack = 1'b0;
  logic slow = 1'b0;
  logic [31:0] hrdata, r;
  logic hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, irq;
  logic scl_pull, sda_pull;
  logic [7:0] last_byte;
  int n_fail = 0;
  int comparisons = 0;
  // open-drain lines with pull-up
  wire scl = ~scl_oe & ~scl_pull;
  wire sda = ~sda_oe & ~sda_pull;
  always #10 hclk = ~hclk;
  tws_top i_tws_top (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata,
    .hreadyout, .hresp, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o,
    .sda_oe, .irq);
  tws_target_model i_tws_target_model (.scl, .sda, .nack, .slow,
    .scl_pull, .sda_pull, .last_byte);
  task automatic close_out;
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one single transfer; read data lands in r
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int k;
    k = 0;
    bus(1'b0, a, 32'h0);
    while ((r & m) !== m && k < 3000) begin
      bus(1'b0, a, 32'h0);
      k++;
    end
    chk("poll", m, r & m);
  endtask : poll
  // load a byte, write control, wait for the flag, check the code
  task automatic step(input logic [7:0] d, input logic [7:0] c,
    input logic [7:0] code);
    bus(1'b1, tws_pkg::OFF_ICLR, 32'h7);
    bus(1'b1, tws_pkg::OFF_DATA, {24'h0, d});
    bus(1'b1, tws_pkg::OFF_CTRL, {24'h0, c});
    bus(1'b0, tws_pkg::OFF_CTRL, 32'h0);
    chk("flag clear", 32'h0, r & 32'h80);
    poll(tws_pkg::OFF_CTRL, 32'h80);
    bus(1'b0, tws_pkg::OFF_STAT, 32'h0);
    chk("status", {24'h0, code}, r & 32'hf8);
    chk("irq", 32'h1, {31'h0, irq});
  endtask : step
  // hang guard, well past the expected run
  initial begin
    #1500000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, tws_pkg::OFF_CTRL, 32'h0);
    chk("ctrl", 32'h0, r);
    bus(1'b0, tws_pkg::OFF_STAT, 32'h0);
    chk("status", 32'hf8, r & 32'hf8);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, r);
    bus(1'b1, tws_pkg::OFF_IEN, 32'h1);
    // data write collides because the flag is still low
    step(8'h11, 8'ha4, tws_pkg::SC_START);
    bus(1'b0, tws_pkg::OFF_DATA, 32'h0);
    chk("discarded", 32'h0, r);
    bus(1'b0, tws_pkg::OFF_CTRL, 32'h0);
    chk("collision", 32'h8, r & 32'h8);
    bus(1'b0, tws_pkg::OFF_IST, 32'h0);
    chk("int status", 32'h3, r);
    // longer than a bit: the clock must stay held
    repeat (600) @(posedge hclk);
    chk("stall", 32'h1, {31'h0, scl_oe});
    step(8'ha4, 8'h84, 8'h18);
    chk("wire byte", 32'ha4, {24'h0, last_byte});
    nack <= 1'b1;
    slow <= 1'b1;
    step(8'h5b, 8'h84, tws_pkg::SC_DATA_SENT_NACKED);
    chk("wire byte", 32'h5b, {24'h0, last_byte});
    nack <= 1'b0;
    slow <= 1'b0;
    step(8'h00, 8'ha4, tws_pkg::SC_RSTART);
    step(8'ha5, 8'h84, tws_pkg::SC_RADR_ACK);
    chk("wire byte", 32'ha5, {24'h0, last_byte});
    bus(1'b1, tws_pkg::OFF_ICLR, 32'h7);
    bus(1'b1, tws_pkg::OFF_CTRL, 32'h94);
    poll(tws_pkg::OFF_STAT, 32'hf8);
    bus(1'b0, tws_pkg::OFF_IST, 32'h0);
    chk("stop seen", 32'h4, r & 32'h4);
    chk("lines free", 32'h0, {30'h0, scl_oe, sda_oe});
    chk("irq masked", 32'h0, {31'h0, irq});
    close_out();
  end
endmodule : tws_top_tb
